//--- logic/vpsm_consts.svh
// offsets, field positions, reset values and timing counts of the pixel path
// assumes inclusion by bare name from the design modules
`ifndef VPSM_CONSTS_SVH
`define VPSM_CONSTS_SVH

// clock, element and field phase waves
`define VPSM_CLK_HZ          50000000
`define VPSM_ELEM_PHASE_HZ   7000000
`define VPSM_FIELD_PHASE_HZ  30
// half period of the element phase wave, rounded down, at least one cycle
`define VPSM_ELEM_HALF_CYC   ((`VPSM_CLK_HZ / (2 * `VPSM_ELEM_PHASE_HZ)) > 0 ? \
                              (`VPSM_CLK_HZ / (2 * `VPSM_ELEM_PHASE_HZ)) : 1)

// register offsets
`define VPSM_ADDR_W          8
`define VPSM_REG_CTRL        8'h00
`define VPSM_REG_MIXSEL      8'h04
`define VPSM_REG_DACW        8'h08
`define VPSM_REG_DIM         8'h0C
`define VPSM_REG_LUTA        8'h10
`define VPSM_REG_LUTD        8'h14
`define VPSM_REG_STAT        8'h18

// control fields
`define VPSM_CTRL_ELEM_RES   0
`define VPSM_CTRL_FIELD_RES  1
`define VPSM_CTRL_COMBINE    2
`define VPSM_CTRL_RST        3'h0

// mixer input select codes, five bits per configurable input
`define VPSM_SEL_W           5
`define VPSM_SEL_NATIVE      5'h00
`define VPSM_SEL_INACTIVE    5'h01
`define VPSM_SEL_BLINK       5'h02
`define VPSM_SEL_SUB_BASE    5'h10
`define VPSM_MIXSEL_RST      20'h00000

// converter widths and dim mask reset
`define VPSM_W4_W            3
`define VPSM_W8_W            4
`define VPSM_W4_RST          3'h4
`define VPSM_W8_RST          4'h8
`define VPSM_DIM_RST         4'hF

`endif

//--- logic/vpsm_pkg.sv
// types shared by the pixel select and mix path
// assumes nothing outside itself
package vpsm_pkg;

    localparam int VPSM_NUM_SUB = 12;
    localparam int VPSM_NUM_TAB = 4;

    // one bit per subchannel for each field and element
    typedef struct packed {
        logic [VPSM_NUM_SUB-1:0] b_odd;
        logic [VPSM_NUM_SUB-1:0] b_even;
        logic [VPSM_NUM_SUB-1:0] a_odd;
        logic [VPSM_NUM_SUB-1:0] a_even;
    } vpsm_mem_lines_t;

    typedef struct packed {
        logic vert_drive;
        logic comp_sync;
        logic horiz_drive;
        logic comp_blank;
    } vpsm_timing_t;

endpackage

//--- logic/vpsm_mix_table.sv
// one mixing lookup table: nine inputs in, three inverted video bits out
// assumes writes come from the register port of the top module
`timescale 1ns/1ps
`include "vpsm_consts.svh"

module vpsm_mix_table
    import vpsm_pkg::*;
#(
    parameter int AW = 9,
    parameter int DW = 3
) (
    // clock
    input  wire logic          clk,
    // table load
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // lookup
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    if (AW < 1 || DW < 1) begin : g_chk
        $error("vpsm_mix_table: widths must be positive");
    end

    logic [DW-1:0] mem_q [2**AW];

    // contents set colour and routing of each cursor and overlay
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    assign rd_data = ~mem_q[rd_addr];

endmodule // vpsm_mix_table

//--- logic/vpsm_dac_route.sv
// converter bit routing: the top WIDTH bits take the low source bits,
// lower converter inputs are grounded
// assumes width codes come from a register
`timescale 1ns/1ps
`include "vpsm_consts.svh"

module vpsm_dac_route
    import vpsm_pkg::*;
#(
    parameter int N  = 4,
    parameter int WW = 3
) (
    // routing
    input  wire logic [N-1:0]  src,
    input  wire logic [WW-1:0] width,
    output logic      [N-1:0]  dst
);

    if (N < 2 || (2**WW) <= N) begin : g_chk
        $error("vpsm_dac_route: width code too narrow for N");
    end

    // source bit w-1 is the converter msb
    always_comb begin
        int w;
        w = (int'(width) > N) ? N : int'(width);
        dst = '0;
        for (int i = 0; i < N; i++) begin
            if (i >= N - w) begin
                dst[i] = src[i-(N-w)];
            end
        end
    end

endmodule // vpsm_dac_route

//--- logic/vpsm_pixel_path.sv
// top of the pixel select and mix path of a raster video output board
// assumes all inputs synchronous to clk; clk is the full-rate clock, the
// half-rate capture stage is kept as a phase of it
`timescale 1ns/1ps
`include "vpsm_consts.svh"

module vpsm_pixel_path
    import vpsm_pkg::*;
#(
    parameter int LUT_AW = 9,
    parameter int ELEM_HALF_CYC = `VPSM_ELEM_HALF_CYC
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // register port
    input  wire logic [`VPSM_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    // refresh memory and timing board
    input  wire vpsm_mem_lines_t        refresh_mem_lines,
    input  wire vpsm_timing_t           timing_in,
    input  wire logic                   field_phase_wave,
    input  wire logic [3:0]             cursor_in,
    input  wire logic                   blink_osc_in,
    // video outputs
    output logic [VPSM_NUM_SUB-1:0]     mixed_bit,
    output logic [VPSM_NUM_SUB-1:0]     converter_bit_in,
    output logic [3:0]                  cursor_dim,
    output vpsm_timing_t                timing_out
);

    // the element phase counter is eight bits wide
    if (LUT_AW != 9 || ELEM_HALF_CYC < 1 || ELEM_HALF_CYC > 256) begin : g_chk
        $error("vpsm_pixel_path: table needs nine inputs, half period 1..256");
    end

    // ---------------- registers ----------------
    logic [2:0]                  ctrl_q;
    logic [`VPSM_SEL_W*4-1:0]    mixsel_q;
    logic [`VPSM_W4_W-1:0]       w4_q [3];
    logic [`VPSM_W8_W-1:0]       w8_q;
    logic [3:0]                  dim_mask_q;
    logic [LUT_AW+1:0]           luta_q;
    logic [31:0]                 rdata_q;

    wire hit_ctrl   = reg_addr == `VPSM_REG_CTRL;
    wire hit_mixsel = reg_addr == `VPSM_REG_MIXSEL;
    wire hit_dacw   = reg_addr == `VPSM_REG_DACW;
    wire hit_dim    = reg_addr == `VPSM_REG_DIM;
    wire hit_luta   = reg_addr == `VPSM_REG_LUTA;
    wire hit_lutd   = reg_addr == `VPSM_REG_LUTD;
    wire hit_stat   = reg_addr == `VPSM_REG_STAT;
    wire lut_wr     = reg_wr && hit_lutd;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q     <= `VPSM_CTRL_RST;
            mixsel_q   <= `VPSM_MIXSEL_RST;
            w4_q       <= '{`VPSM_W4_RST, `VPSM_W4_RST, `VPSM_W4_RST};
            w8_q       <= `VPSM_W8_RST;
            dim_mask_q <= `VPSM_DIM_RST;
            luta_q     <= '0;
        end else if (reg_wr) begin
            if (hit_ctrl) begin
                ctrl_q <= reg_wdata[2:0];
            end
            if (hit_mixsel) begin
                mixsel_q <= reg_wdata[`VPSM_SEL_W*4-1:0];
            end
            if (hit_dacw) begin
                w4_q[0] <= reg_wdata[2:0];
                w4_q[1] <= reg_wdata[5:3];
                w4_q[2] <= reg_wdata[8:6];
                w8_q    <= reg_wdata[12:9];
            end
            if (hit_dim) begin
                dim_mask_q <= reg_wdata[3:0];
            end
            if (hit_luta) begin
                luta_q <= reg_wdata[LUT_AW+1:0];
            end
            if (hit_lutd) begin
                luta_q <= luta_q + (LUT_AW+2)'(1);
            end
        end
    end

    // ---------------- timing and select controls ----------------
    logic              half_phase_q;
    vpsm_timing_t      tim1_q;
    vpsm_timing_t      tim2_q;
    logic [7:0]        ecnt_q;
    logic              element_phase_wave;
    logic              element_phase_q;
    wire               aligned_comp_blank = tim1_q.comp_blank;
    wire [7:0]         ecnt_last = 8'(ELEM_HALF_CYC - 1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            half_phase_q    <= 1'b0;
            ecnt_q          <= 8'h00;
            element_phase_q <= 1'b0;
        end else begin
            half_phase_q <= ~half_phase_q;
            // element phase restarts with each blanking interval
            if (aligned_comp_blank) begin
                ecnt_q          <= 8'h00;
                element_phase_q <= 1'b0;
            end else if (ecnt_q == ecnt_last) begin
                ecnt_q          <= 8'h00;
                element_phase_q <= ~element_phase_q;
            end else begin
                ecnt_q <= ecnt_q + 8'h01;
            end
        end
    end

    assign element_phase_wave = element_phase_q;

    wire element_select = ctrl_q[`VPSM_CTRL_ELEM_RES]
                          & element_phase_wave;
    wire field_select   = ctrl_q[`VPSM_CTRL_FIELD_RES]
                          & field_phase_wave;

    // timing follows the data stages
    always_ff @(posedge clk) begin
        tim1_q <= timing_in;
        tim2_q <= tim1_q;
    end

    // ---------------- data capture and selection ----------------
    vpsm_mem_lines_t           hold_q;
    logic [VPSM_NUM_SUB-1:0]   selected_subchannels;
    logic [VPSM_NUM_SUB-1:0]   sel_d;
    logic [3:0]                cur1_q;
    logic [3:0]                cur_q;

    // half-rate capture: loads only on the low half phase
    always_ff @(posedge clk) begin
        hold_q <= half_phase_q ? hold_q : refresh_mem_lines;
    end

    wire [VPSM_NUM_SUB-1:0] field_a = element_select ? hold_q.a_odd
                                                     : hold_q.a_even;
    wire [VPSM_NUM_SUB-1:0] field_b = element_select ? hold_q.b_odd
                                                     : hold_q.b_even;
    // low levels pick even and A blanking forces ones
    assign sel_d = aligned_comp_blank ? {VPSM_NUM_SUB{1'b1}}
                 : (field_select ? field_b : field_a);

    always_ff @(posedge clk) begin
        selected_subchannels <= sel_d;
        cur1_q <= cursor_in;
        cur_q  <= cur1_q & {4{~aligned_comp_blank}};
    end

    // ---------------- mixer input selection ----------------
    function automatic logic pick_src(
        input logic [`VPSM_SEL_W-1:0]  code,
        input logic                    native,
        input logic [VPSM_NUM_SUB-1:0] sub,
        input logic                    blink
    );
        logic [`VPSM_SEL_W-1:0] idx;
        idx = code - `VPSM_SEL_SUB_BASE;
        if (code == `VPSM_SEL_NATIVE) begin
            return native;
        end else if (code == `VPSM_SEL_INACTIVE) begin
            return 1'b1;
        end else if (code == `VPSM_SEL_BLINK) begin
            return blink;
        end else if (code >= `VPSM_SEL_SUB_BASE
                     && int'(idx) < VPSM_NUM_SUB) begin
            return sub[idx[3:0]];
        end
        return 1'b1;
    endfunction

    wire [`VPSM_SEL_W-1:0] code_a = mixsel_q[4:0];
    wire [`VPSM_SEL_W-1:0] code_b = mixsel_q[9:5];
    wire [`VPSM_SEL_W-1:0] code_c = mixsel_q[14:10];
    wire [`VPSM_SEL_W-1:0] code_d = mixsel_q[19:15];

    // native sources: inactive overlays and cursors three, four
    // any other code picks inactive, blink or a subchannel
    wire overlay_in_a   = pick_src(code_a, 1'b1, selected_subchannels,
                                   blink_osc_in);
    wire overlay_in_b   = pick_src(code_b, 1'b1, selected_subchannels,
                                   blink_osc_in);
    wire mixer_cfg_in_c = pick_src(code_c, cur_q[2], selected_subchannels,
                                   blink_osc_in);
    wire mixer_cfg_in_d = pick_src(code_d, cur_q[3], selected_subchannels,
                                   blink_osc_in);
    wire mixer_cursor_a = cur_q[0];
    wire mixer_cursor_b = cur_q[1];

    // ---------------- mixing tables ----------------
    logic [VPSM_NUM_SUB-1:0] mix_d;

    for (genvar t = 0; t < VPSM_NUM_TAB; t++) begin : g_tab
        wire [LUT_AW-1:0] addr = {mixer_cfg_in_d, mixer_cfg_in_c,
                                  overlay_in_b, overlay_in_a,
                                  mixer_cursor_b, mixer_cursor_a,
                                  selected_subchannels[3*t+2:3*t]};
        vpsm_mix_table #(
            .AW (LUT_AW),
            .DW (3)
        ) u_tab (
            .clk     (clk),
            .wr_en   (lut_wr && luta_q[LUT_AW+1:LUT_AW] == 2'(t)),
            .wr_addr (luta_q[LUT_AW-1:0]),
            .wr_data (reg_wdata[2:0]),
            .rd_addr (addr),
            .rd_data (mix_d[3*t+2:3*t])
        );
    end

    // ---------------- converter routing ----------------
    logic [VPSM_NUM_SUB-1:0] route4;
    logic [7:0]              route8;
    wire                     combine = ctrl_q[`VPSM_CTRL_COMBINE];

    for (genvar k = 0; k < 3; k++) begin : g_dac4
        vpsm_dac_route #(
            .N  (4),
            .WW (`VPSM_W4_W)
        ) u_route (
            .src   (mix_d[4*k+3:4*k]),
            .width (w4_q[k]),
            .dst   (route4[4*k+3:4*k])
        );
    end

    vpsm_dac_route #(
        .N  (8),
        .WW (`VPSM_W8_W)
    ) u_route8 (
        .src   (mix_d[7:0]),
        .width (w8_q),
        .dst   (route8)
    );

    wire [VPSM_NUM_SUB-1:0] conv_d = combine ? {route4[11:8], route8}
                                             : route4;

    // ---------------- output stage ----------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mixed_bit        <= '0;
            converter_bit_in <= '0;
            cursor_dim       <= 4'h0;
            timing_out       <= '0;
        end else begin
            mixed_bit        <= mix_d;
            converter_bit_in <= conv_d;
            cursor_dim       <= cur_q & dim_mask_q;
            timing_out       <= tim2_q;
        end
    end

    // ---------------- register read ----------------
    wire [31:0] stat_word = {28'h0000000, element_phase_wave,
                             aligned_comp_blank, field_select,
                             element_select};
    wire [31:0] dacw_word = {19'h00000, w8_q, w4_q[2], w4_q[1], w4_q[0]};
    wire [31:0] rd_mux =
        hit_ctrl   ? {29'h00000000, ctrl_q} :
        hit_mixsel ? {12'h000, mixsel_q} :
        hit_dacw   ? dacw_word :
        hit_dim    ? {28'h0000000, dim_mask_q} :
        hit_luta   ? {21'h000000, luta_q} :
        hit_stat   ? stat_word : 32'h00000000;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    assign reg_rdata = rdata_q;

endmodule // vpsm_pixel_path

//--- tb/vpsm_pixel_path_assertions.sv
// checker on the pixel path ports: delays, blanking, status bits
// assumes a bind to vpsm_pixel_path and one clock domain
`timescale 1ns/1ps
`include "vpsm_consts.svh"

module vpsm_chk
    import vpsm_pkg::*;
(
    // clock and reset
    input wire logic                    clk,
    input wire logic                    rst_n,
    // register port
    input wire logic [`VPSM_ADDR_W-1:0] reg_addr,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [31:0]             reg_rdata,
    // pixel side
    input wire vpsm_timing_t            timing_in,
    input wire logic [3:0]              cursor_in,
    input wire logic                    blink_osc_in,
    input wire logic [VPSM_NUM_SUB-1:0] mixed_bit,
    input wire logic [VPSM_NUM_SUB-1:0] converter_bit_in,
    input wire logic [3:0]              cursor_dim,
    input wire vpsm_timing_t            timing_out
);
    // keeps delayed values from reaching back into reset
    logic [2:0] warm_q;
    wire        warm = warm_q == 3'h7;
    always_ff @(posedge clk) begin
        if (!rst_n)
            warm_q <= 3'h0;
        else if (!warm)
            warm_q <= warm_q + 3'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_tim_dly;
        warm |-> timing_out == $past(timing_in, 3);
    endproperty
    a_tim_dly: assert property (p_tim_dly)
        else $error("timing out not input delayed three");
    property p_sync_sep;
        warm && $rose(timing_in.comp_sync) && $stable(timing_in.vert_drive)
            |-> ##3 $rose(timing_out.comp_sync)
            && $stable(timing_out.vert_drive);
    endproperty
    a_sync_sep: assert property (p_sync_sep)
        else $error("sync output not separate");
    property p_dim_sub;
        warm |-> (cursor_dim & ~$past(cursor_in, 3)) == 4'h0;
    endproperty
    a_dim_sub: assert property (p_dim_sub)
        else $error("dim signal without its cursor");
    property p_dim_blank;
        warm && timing_in.comp_blank |-> ##3 cursor_dim == 4'h0;
    endproperty
    a_dim_blank: assert property (p_dim_blank)
        else $error("cursor not gated by blanking");
    property p_blank_hold;
        (warm && timing_in.comp_blank && !reg_wr && $stable(blink_osc_in)) [*5]
            |-> $stable(mixed_bit) && $stable(converter_bit_in);
    endproperty
    a_blank_hold: assert property (p_blank_hold)
        else $error("video moves during blanking");
    property p_rd_idle;
        warm && !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read answer");
    property p_stat_elem;
        reg_rd && reg_addr == `VPSM_REG_STAT |=> !reg_rdata[0] || reg_rdata[3];
    endproperty
    a_stat_elem: assert property (p_stat_elem)
        else $error("element select without phase wave");
    property p_stat_blank;
        warm && reg_rd && reg_addr == `VPSM_REG_STAT && timing_in.comp_blank
            && $past(timing_in.comp_blank) |=> reg_rdata[2];
    endproperty
    a_stat_blank: assert property (p_stat_blank)
        else $error("aligned blanking status low");

    c_stat: cover property (reg_rd && reg_addr == `VPSM_REG_STAT);
    c_blank: cover property (warm && timing_in.comp_blank [*5]);
    c_dim: cover property (cursor_dim != 4'h0);
endmodule // vpsm_chk

bind vpsm_pixel_path vpsm_chk u_chk (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timing_in(timing_in),
    .cursor_in(cursor_in), .blink_osc_in(blink_osc_in),
    .mixed_bit(mixed_bit), .converter_bit_in(converter_bit_in),
    .cursor_dim(cursor_dim), .timing_out(timing_out)
);

//--- tb/vpsm_far_model.sv
// refresh memory model feeding the pixel path data lines
// assumes the bench changes resolution and data just after a clock edge
`timescale 1ns/1ps

module vpsm_far_model
    import vpsm_pkg::*;
(
    // from the bench
    input  wire logic [1:0]      res,
    input  wire vpsm_mem_lines_t pix,
    // toward the pixel path
    output vpsm_mem_lines_t      mem
);
    // lines unused at a resolution float to the pull-up level
    localparam logic [VPSM_NUM_SUB-1:0] PULL = '1;
    assign mem.a_even = pix.a_even;
    assign mem.a_odd  = res != 2'h0 ? pix.a_odd : PULL;
    assign mem.b_even = res == 2'h2 ? pix.b_even : PULL;
    assign mem.b_odd  = res == 2'h2 ? pix.b_odd : PULL;
endmodule // vpsm_far_model

//--- tb/testbench.sv
// self-checking bench of the pixel select and mix path
// assumes the far model, the checker bind and the design are compiled
`timescale 1ns/1ps

module testbench;
    import vpsm_pkg::*;
    localparam int HALF = 3;
    localparam logic [7:0]  RA[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                      8'h14, 8'h1C};
    localparam logic [31:0] RV[7] = '{32'h0, 32'h0, 32'h1124, 32'hF,
                                      32'h0, 32'h0, 32'h0};
    localparam logic [4:0]  CD[16] = '{5'h00, 5'h01, 5'h02, 5'h10, 5'h11,
        5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A,
        5'h1B, 5'h1F};
    logic            clk = 1'b0, rst_n = 1'b0;
    logic [7:0]      reg_addr = 8'h00;
    logic [31:0]     reg_wdata = 32'h0, reg_rdata;
    logic            reg_wr = 1'b0, reg_rd = 1'b0;
    logic            fwave = 1'b0, blink = 1'b0, smp = 1'b0, rd_seen = 1'b0;
    logic [1:0]      res = 2'h0;
    vpsm_mem_lines_t pix = '0, mem;
    vpsm_timing_t    tin = '0, tout;
    logic [3:0]      cur = 4'h0, dim, dmask;
    logic [11:0]     mix, conv;
    logic [2:0]      ctrl;
    logic [19:0]     msel;
    logic [12:0]     dacw;
    logic [31:0]     q[$];
    logic [31:0]     seed = 32'h14808B9F;
    int              n_errors = 0, checked = 0;

    always #10 clk = ~clk;

    vpsm_pixel_path #(.ELEM_HALF_CYC(HALF)) u_dut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .refresh_mem_lines(mem),
        .timing_in(tin), .field_phase_wave(fwave), .cursor_in(cur),
        .blink_osc_in(blink), .mixed_bit(mix),
        .converter_bit_in(conv), .cursor_dim(dim), .timing_out(tout));
    vpsm_far_model u_far (.res(res), .pix(pix), .mem(mem));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] lutv(logic [10:0] a);
        return a[2:0] ^ a[5:3] ^ a[8:6] ^ {1'b0, a[10:9]};
    endfunction
    function automatic logic [7:0] route(logic [7:0] s, int n, int w);
        logic [7:0] r;
        r = 8'h00;
        if (w > n)
            w = n;
        for (int i = 0; i < w; i++)
            r[n-w+i] = s[i];
        return r;
    endfunction
    // steady-state outputs for the present inputs and register settings
    function automatic logic [31:0] expect_out();
        logic [11:0] sub, m;
        logic [3:0]  c, in4;
        logic [7:0]  cv, hi;
        logic [4:0]  cd;
        sub = ctrl[1] & fwave ? mem.b_even : mem.a_even;
        if (tin.comp_blank)
            sub = '1;
        c = cur & {4{~tin.comp_blank}};
        for (int k = 0; k < 4; k++) begin
            cd = msel[5*k +: 5];
            in4[k] = cd == 5'h02 ? blink : cd == 5'h00 ? (k > 1 ? c[k] : 1'b1)
                : cd[4] && cd[3:0] < 4'hC ? sub[cd[3:0]] : 1'b1;
        end
        for (int t = 0; t < 4; t++)
            m[3*t +: 3] = ~lutv({t[1:0], in4, c[1:0], sub[3*t +: 3]});
        cv = ctrl[2] ? route(m[7:0], 8, dacw[12:9])
            : route({4'h0, m[3:0]}, 4, dacw[2:0])
            | (route({4'h0, m[7:4]}, 4, dacw[5:3]) << 4);
        hi = route({4'h0, m[11:8]}, 4, dacw[8:6]);
        return {tin, c & dmask, hi[3:0], cv, m};
    endfunction

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        q.push_back(e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic vid();
        repeat (8) @(posedge clk);
        q.push_back(expect_out());
        smp <= 1'b1;
        @(posedge clk);
        smp <= 1'b0;
    endtask
    task automatic cmp(logic [31:0] got);
        logic [31:0] e;
        e = q.pop_front();
        checked++;
        if (got !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(negedge clk) begin
        if (rd_seen)
            cmp(reg_rdata);
        if (smp)
            cmp({tout, dim, conv, mix});
        rd_seen = reg_rd;
    end

    initial begin
        logic [31:0] r;
        logic [63:0] w;
        logic [11:0] prev;
        int          n;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (RA[i]) rd(RA[i], RV[i]);
        $display("reset values done");
        wr(8'h10, 32'h0);
        for (int i = 0; i < 2048; i++)
            wr(8'h14, {29'h0, lutv(i[10:0])});
        rd(8'h10, 32'h0);
        $display("table load done");
        for (int i = 0; i < 150; i++) begin
            r = rnd();
            w = {rnd(), rnd()};
            ctrl = {r[2:1], 1'b0};
            msel = {CD[r[31:28]], CD[r[27:24]], CD[r[23:20]], CD[r[19:16]]};
            dacw = w[12:0];
            dmask = w[16:13];
            if (i == 0)
                msel = 20'h0;
            if (i == 1) begin
                msel[4:0] = 5'h13;
                dacw[2:0] = 3'h3;
            end
            wr(8'h00, {29'h0, ctrl});
            wr(8'h04, {12'h0, msel});
            wr(8'h08, {19'h0, dacw});
            wr(8'h0C, {28'h0, dmask});
            pix <= w[63:16];
            res <= w[17:16] == 2'h3 ? 2'h2 : w[17:16];
            tin <= r[6:3];
            cur <= r[10:7];
            blink <= r[11];
            fwave <= r[12];
            vid();
            if (tin.comp_blank)
                rd(8'h18, {28'h0, 2'b01, ctrl[1] & fwave, 1'b0});
        end
        $display("mix sweep done");
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h1);
        tin <= '0;
        cur <= 4'h0;
        res <= 2'h1;
        pix.a_even <= 12'h000;
        pix.a_odd <= 12'hFFF;
        repeat (8) @(posedge clk);
        n = 0;
        for (int i = 0; i < 30; i++) begin
            @(negedge clk);
            if (i > 0 && mix !== prev)
                n++;
            prev = mix;
        end
        q.push_back(32'h1);
        cmp({31'h0, n >= 29 / HALF && n <= 29 / HALF + 1});
        $display("element phase done");
        stop_test();
    end
endmodule // testbench
